// ---- common/jfc_pkg.sv ----
// Purpose: Constants and types for the test-port fuse check mode logic.
// Assumes: One power-on reset drives sys_rst; pin levels arrive unsynchronised.
// Notes:   Shared by the design and by the bench.
// Notes on behaviour
// RL1 - Check fuse once per power-up, fused parts only
// RL2 - First mode-select falling edge arms the check
// RL3 - Mode-select low at power-up arms immediately
// RL4 - Second rising edge since power-up ends check
// RL5 - After ending, stays off until power-on reset
// RL6 - Masked parts: current only when active and low
// RL7 - Programmable parts: current whole time check active
// RL8 - Host keeps mode-select high, avoids stray edges
// RL9 - Blown fuse refuses all test port access
// RL10 - Power-on reset clears flag, counter, ended latch
package jfc_pkg;

    // Depth of each pin synchroniser
    localparam int          SYNC_DEPTH  = 3;
    // Number of synchronised pins and their bit positions
    localparam int          PIN_COUNT   = 2;
    localparam int          PIN_TMS     = 0;
    localparam int          PIN_FUSE    = 1;
    // Idle level of each pin after reset (pull-up on mode-select, fuse intact)
    localparam logic [1:0]  PIN_IDLE    = 2'h1;
    // Rising edges since power-up that end the check
    localparam logic [1:0]  LEAVE_RISES = 2'h2;
    // Cycles after reset release before the first pin level is trusted
    localparam logic [1:0]  BOOT_CYCLES = 2'h3;
    // Link-side crossing depth
    localparam int          LINK_SYNC   = 2;

    // Check mode states
    typedef enum logic [1:0] {
        JFC_BOOT   = 2'b00,
        JFC_ARMED  = 2'b01,
        JFC_ACTIVE = 2'b10,
        JFC_DONE   = 2'b11
    } jfc_state_t;

endpackage

// ---- src/jfc_fuse_check.sv ----
// Purpose: Fuse continuity check mode control, watching the test mode-select pin.
// Assumes: clk 50 MHz; tck is the test port clock and may stop between accesses.
// Notes:   Only the clk domain obeys ce; the tck side just re-times a level.
`timescale 1ns/10ps

module jfc_fuse_check #(
    parameter bit HAS_FUSE    = 1'b1,
    parameter bit OTP_VERSION = 1'b0
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    input  wire logic tms_pin,
    input  wire logic fuse_blown_pin,
    input  wire logic tck,
    output logic      check_active,
    output logic      fuse_check_current,
    output logic      access_ok,
    output logic      test_access_en
);
    import jfc_pkg::*;

    logic [PIN_COUNT-1:0]  sync_a;
    logic [PIN_COUNT-1:0]  sync_b;
    logic [PIN_COUNT-1:0]  sync_c;
    logic [PIN_COUNT-1:0]  pin_lvl;
    logic [PIN_COUNT-1:0]  next_pin_lvl;
    logic [1:0]            boot_cnt;
    logic [1:0]            rise_cnt;
    jfc_state_t            state;
    jfc_state_t            next_state;
    logic                  tms_fall;
    logic                  tms_rise;
    logic                  boot_done;
    logic                  boot_low;
    logic                  next_current;
    logic [LINK_SYNC-1:0]  link_sync;

    // Three-stage synchronisers, one per pin; level moves when stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++)
        begin : g_pin
            always_ff @(posedge clk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    sync_a[gi]  <= PIN_IDLE[gi];
                    sync_b[gi]  <= PIN_IDLE[gi];
                    sync_c[gi]  <= PIN_IDLE[gi];
                    pin_lvl[gi] <= PIN_IDLE[gi];
                end
                else if (ce)
                begin
                    sync_a[gi]  <= (gi == PIN_TMS) ? tms_pin : fuse_blown_pin;
                    sync_b[gi]  <= sync_a[gi];
                    sync_c[gi]  <= sync_b[gi];
                    pin_lvl[gi] <= next_pin_lvl[gi];
                end
            end
            assign next_pin_lvl[gi] = (sync_b[gi] == sync_c[gi]) ? sync_c[gi] : pin_lvl[gi];
        end
    endgenerate

    // Edge and boot decode on the filtered mode-select level
    assign tms_fall  = pin_lvl[PIN_TMS] & ~next_pin_lvl[PIN_TMS];
    assign tms_rise  = ~pin_lvl[PIN_TMS] & next_pin_lvl[PIN_TMS];
    assign boot_done = (boot_cnt == BOOT_CYCLES);
    assign boot_low  = ~next_pin_lvl[PIN_TMS];

    // State sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            JFC_BOOT:
            begin
                if (boot_done)
                begin
                    if (boot_low && HAS_FUSE && access_ok)                // RL3 RL1
                        next_state = JFC_ACTIVE;
                    else
                        next_state = JFC_ARMED;
                end
            end
            JFC_ARMED:
            begin
                if ((rise_cnt == LEAVE_RISES - 2'h1) && tms_rise)       // RL4
                    next_state = JFC_DONE;
                else if (tms_fall && HAS_FUSE && access_ok)             // RL2 RL1 RL9
                    next_state = JFC_ACTIVE;
            end
            JFC_ACTIVE:
            begin
                if ((rise_cnt == LEAVE_RISES - 2'h1) && tms_rise)       // RL4
                    next_state = JFC_DONE;
            end
            JFC_DONE:   next_state = JFC_DONE;                         // RL5
            default:    next_state = JFC_BOOT;
        endcase
    end

    // Current gate by part type
    assign next_current = (next_state == JFC_ACTIVE) &&
                          (OTP_VERSION || ~next_pin_lvl[PIN_TMS]);      // RL6 RL7

    // State, counters and registered outputs
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)                                                   // RL10
        begin
            state              <= JFC_BOOT;
            boot_cnt           <= 2'h0;
            rise_cnt           <= 2'h0;
            check_active       <= 1'b0;
            fuse_check_current <= 1'b0;
            access_ok          <= 1'b0;
        end
        else if (ce)
        begin
            state              <= next_state;
            boot_cnt           <= boot_done ? boot_cnt : boot_cnt + 2'h1;
            rise_cnt           <= (tms_rise && rise_cnt != LEAVE_RISES) ? rise_cnt + 2'h1 : rise_cnt;
            check_active       <= (next_state == JFC_ACTIVE);
            fuse_check_current <= next_current;
            access_ok          <= ~next_pin_lvl[PIN_FUSE];             // RL9
        end
    end

    // Test port clock side: two-stage crossing of the access permission
    always_ff @(posedge tck or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            link_sync      <= '0;
            test_access_en <= 1'b0;
        end
        else
        begin
            link_sync      <= {link_sync[LINK_SYNC-2:0], access_ok};
            test_access_en <= link_sync[LINK_SYNC-1];                  // RL9
        end
    end

    // Checks
    sequence s_active_rise_last;
        ce && state == JFC_ACTIVE && tms_rise && rise_cnt == LEAVE_RISES - 2'h1;
    endsequence

    sequence s_armed_rise_last;
        ce && state == JFC_ARMED && tms_rise && rise_cnt == LEAVE_RISES - 2'h1;
    endsequence

    sequence s_armed_fall;
        ce && state == JFC_ARMED && tms_fall && !tms_rise && rise_cnt != LEAVE_RISES && access_ok;
    endsequence

    a_fall_arms: assert property (@(posedge clk) disable iff (sys_rst) // RL2
        s_armed_fall |=> (state == (HAS_FUSE ? JFC_ACTIVE : JFC_ARMED)))
        else $error("falling edge did not arm the check");

    a_boot_low_arms: assert property (@(posedge clk) disable iff (sys_rst) // RL3
        (ce && state == JFC_BOOT && boot_done && boot_low && access_ok && HAS_FUSE) |=> check_active)
        else $error("low level at power-up did not arm the check");

    a_second_rise: assert property (@(posedge clk) disable iff (sys_rst) // RL4
        s_active_rise_last |=> (state == JFC_DONE && !check_active && !fuse_check_current))
        else $error("second rising edge did not end the check");

    a_done_sticky: assert property (@(posedge clk) disable iff (sys_rst) // RL5
        (state == JFC_DONE) |=> (state == JFC_DONE) [*2] ##0 !check_active)
        else $error("check left the ended state");

    a_rom_current: assert property (@(posedge clk) disable iff (sys_rst) // RL6
        (!OTP_VERSION && fuse_check_current) |-> (check_active && !pin_lvl[PIN_TMS]))
        else $error("masked part drew current with mode-select high");

    a_otp_current: assert property (@(posedge clk) disable iff (sys_rst) // RL7
        (OTP_VERSION && ce && next_state == JFC_ACTIVE) |=> fuse_check_current)
        else $error("programmable part dropped current while active");

    a_no_fuse: assert property (@(posedge clk) disable iff (sys_rst) // RL1
        (!HAS_FUSE) |-> (!check_active && !fuse_check_current))
        else $error("check ran on a part without fuse");

    // Entry and exit order
    a_high_boot_waits: assert property (@(posedge clk) disable iff (sys_rst) // RL2
        (ce && state == JFC_BOOT && boot_done && !boot_low) |=> (state == JFC_ARMED && !check_active))
        else $error("check armed without a falling edge");

    a_active_holds: assert property (@(posedge clk) disable iff (sys_rst) // RL4
        (state == JFC_ACTIVE && !(tms_rise && rise_cnt == LEAVE_RISES - 2'h1)) |=> check_active)
        else $error("check ended before the second rising edge");

    a_armed_rise_ends: assert property (@(posedge clk) disable iff (sys_rst) // RL4 RL5
        s_armed_rise_last |=> (state == JFC_DONE && !check_active))
        else $error("second rising edge while armed did not end the check");

    a_done_ignores: assert property (@(posedge clk) disable iff (sys_rst) // RL5
        (state == JFC_DONE && tms_fall) |=> !check_active)
        else $error("falling edge re-armed an ended check");

    // Current gating
    a_current_gated: assert property (@(posedge clk) disable iff (sys_rst) // RL6 RL7
        fuse_check_current |-> check_active)
        else $error("fuse check current on while check inactive");

    a_rom_low_draws: assert property (@(posedge clk) disable iff (sys_rst) // RL6
        (!OTP_VERSION && ce && next_state == JFC_ACTIVE && !next_pin_lvl[PIN_TMS]) |=> fuse_check_current)
        else $error("masked part drew no current while active and low");

    // Access refusal; the test clock side needs three edges plus one to show it
    a_blown_no_arm: assert property (@(posedge clk) disable iff (sys_rst) // RL9
        (!access_ok && state != JFC_ACTIVE) |=> !check_active)
        else $error("check armed with fuse blown");

    a_blown_closes: assert property (@(posedge clk) disable iff (sys_rst) // RL9
        (ce && sync_b[PIN_FUSE] && sync_c[PIN_FUSE]) |=> !access_ok)
        else $error("access allowed with fuse blown");

    a_blown_refuse: assert property (@(posedge tck) disable iff (sys_rst) // RL9
        (!access_ok) [*4] |-> !test_access_en)
        else $error("test port open with blown fuse");

    a_reset_clear: assert property (@(posedge clk) // RL10
        sys_rst |-> (state == JFC_BOOT && rise_cnt == 2'h0 && !check_active))
        else $error("reset did not clear the check logic");

endmodule // jfc_fuse_check

// ---- test/jfc_host_model.sv ----
// Purpose: Behavioural test host driving the mode-select and test clock pins.
// Assumes: Callers change levels away from the system clock edge.
// Notes:   tck toggles only inside a frame and rests low between frames.
`timescale 1ns/10ps

module jfc_host_model (
    output logic tms_pin,
    output logic tck
);
    // Idle state: mode-select parked high, clock stopped
    initial
    begin
        tms_pin = 1'b1;
        tck     = 1'b0;
    end

    // Set the mode-select level
    task automatic set_tms(input logic v);
        tms_pin = v;
    endtask

    // Run a frame of 6 ns test clock periods, phase offset from clk
    task automatic frame(input int n);
        #1.7;
        repeat (n)
        begin
            #3 tck = 1'b1;
            #3 tck = 1'b0;
        end
    endtask
endmodule // jfc_host_model

// ---- test/jtag_fuse_check_mode_tb.sv ----
// Purpose: Self-checking bench for the fuse check mode logic, masked and OTP builds.
// Assumes: Outputs settle within 5 clk of a pin change; 8 clk are allowed.
// Notes:   One host model drives the shared mode-select pin of all three builds.
`timescale 1ns/10ps

module jtag_fuse_check_mode_tb;
    import jfc_pkg::*;
    logic clk, sys_rst, ce, fuse_blown_pin, tms_pin, tck;
    logic act_m, cur_m, act_o, cur_o, ok_m, en_m, act_n, cur_n;
    int   error_cnt, checks_done;

    jfc_host_model jfc_host_model_inst (.tms_pin(tms_pin), .tck(tck));
    jfc_fuse_check #(.OTP_VERSION(1'b0)) jfc_fuse_check_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .tms_pin(tms_pin), .fuse_blown_pin(fuse_blown_pin), .tck(tck), .check_active(act_m),
        .fuse_check_current(cur_m), .access_ok(ok_m), .test_access_en(en_m));
    jfc_fuse_check #(.OTP_VERSION(1'b1)) jfc_fuse_check_otp_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .tms_pin(tms_pin), .fuse_blown_pin(fuse_blown_pin), .tck(tck), .check_active(act_o),
        .fuse_check_current(cur_o), .access_ok(), .test_access_en());
    // Build without the fuse: must never arm
    jfc_fuse_check #(.HAS_FUSE(1'b0)) jfc_fuse_check_nf_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .tms_pin(tms_pin), .fuse_blown_pin(fuse_blown_pin), .tck(tck), .check_active(act_n),
        .fuse_check_current(cur_n), .access_ok(), .test_access_en());

    // 50 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Compare one bit
    task automatic chk(input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, got);
        end
    endtask

    // Compare active and current flags of both builds
    task automatic st(input logic am, cm, ao, co);
        chk(am, act_m);
        chk(cm, cur_m);
        chk(ao, act_o);
        chk(co, cur_o);
    endtask

    // Change mode-select and let the outputs settle
    task automatic pin(input logic v);
        @(negedge clk);
        jfc_host_model_inst.set_tms(v);
        repeat (8) @(negedge clk);
    endtask

    // Power-on reset for 2 cycles with a given mode-select level
    task automatic por(input logic v);
        @(negedge clk);
        sys_rst = 1'b1;
        jfc_host_model_inst.set_tms(v);
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        repeat (10) @(negedge clk);
    endtask

    // Full arm, gate and disarm sequence, then stray edges
    task automatic t_edges;
        por(1'b1);
        st(0, 0, 0, 0);
        pin(1'b0);
        st(1, 1, 1, 1);
        chk(1'b0, act_n);
        chk(1'b0, cur_n);
        pin(1'b1);
        st(1, 0, 1, 1);
        pin(1'b0);
        st(1, 1, 1, 1);
        pin(1'b1);
        st(0, 0, 0, 0);
        pin(1'b0);
        st(0, 0, 0, 0);
        pin(1'b1);
        pin(1'b0);
        st(0, 0, 0, 0);
        $display("t_edges done");
    endtask

    // Mode-select low at power-up, then a reset mid-check
    task automatic t_low_boot;
        por(1'b0);
        st(1, 1, 1, 1);
        chk(1'b0, act_n);
        pin(1'b1);
        st(1, 0, 1, 1);
        por(1'b1);
        st(0, 0, 0, 0);
        pin(1'b0);
        pin(1'b1);
        st(1, 0, 1, 1);
        $display("t_low_boot done");
    endtask

    // Clock enable low freezes the pin chain; the edge is taken once it returns
    task automatic t_ce;
        por(1'b1);
        @(negedge clk);
        ce = 1'b0;
        jfc_host_model_inst.set_tms(1'b0);
        repeat (8) @(negedge clk);
        st(0, 0, 0, 0);
        ce = 1'b1;
        repeat (8) @(negedge clk);
        st(1, 1, 1, 1);
        pin(1'b1);
        $display("t_ce done");
    endtask

    // Blown fuse shuts the port and refuses arming
    task automatic t_fuse;
        por(1'b1);
        jfc_host_model_inst.frame(6);
        chk(1'b1, ok_m);
        chk(1'b1, en_m);
        @(negedge clk);
        fuse_blown_pin = 1'b1;
        repeat (8) @(negedge clk);
        jfc_host_model_inst.frame(6);
        chk(1'b0, ok_m);
        chk(1'b0, en_m);
        pin(1'b0);
        st(0, 0, 0, 0);
        $display("t_fuse done");
    endtask

    // Verdict and end of run
    task automatic close_out;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Hang guard
    initial
    begin
        #200000;
        error_cnt++;
        close_out();
    end

    // Main sequence
    initial
    begin
        sys_rst = 1'b1;
        ce = 1'b1;
        fuse_blown_pin = 1'b0;
        error_cnt = 0;
        checks_done = 0;
        t_edges();
        t_low_boot();
        t_ce();
        t_fuse();
        close_out();
    end
endmodule // jtag_fuse_check_mode_tb
